/* File: tb/tb.sv */
/* self-checking bench of tec_timer.
   registers over avalon-mm, pins from tec_pulse_src. */
`timescale 1ns/1ns
`include "tec_regs.svh"
module tb;
logic mclk, srst, avs_read, avs_write, avs_waitrequest;
logic [4:0] avs_address;
logic [31:0] avs_writedata, avs_readdata, rd, c1;
logic match_interrupt_a, capture_interrupt_b, overflow_flag, pin_a, pin_b;
int err_total, n_compared, n_match, n_capb, m, n, d;
int d_es[3] = '{0, 1, 3};
tec_timer uut (.mclk(mclk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .edge_input_a(pin_a), .edge_input_b(pin_b),
    .match_interrupt_a(match_interrupt_a),
    .capture_interrupt_b(capture_interrupt_b),
    .overflow_flag(overflow_flag));
tec_pulse_src src (.mclk(mclk), .pin_a(pin_a), .pin_b(pin_b));
initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
end
always @(posedge mclk) begin
    if (match_interrupt_a === 1'b1) n_match++;
    if (capture_interrupt_b === 1'b1) n_capb++;
end
// ----------------------------------------
// tasks
// ----------------------------------------
task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
        err_total++;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
endtask
task close_out;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
endtask
task bus(input bit wr, input logic [2:0] idx, input logic [31:0] wd);
    int k;
    k = 0;
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    do begin @(posedge mclk); k++; end
    while (avs_waitrequest !== 1'b0 && k < 50);
    if (avs_waitrequest !== 1'b0) begin err_total++; close_out; end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
endtask
task rdc(input logic [2:0] idx, input logic [31:0] exp);
    bus(0, idx, 32'h0000_0000);
    chk(rd, exp);
endtask
task start(input logic [31:0] md, input logic [31:0] pr,
           input logic [31:0] cmp);
    bus(1, `TEC_IDX_MODE, 32'h0000_0000);
    bus(1, `TEC_IDX_CMPA, cmp);
    bus(1, `TEC_IDX_PRM, pr);
    bus(1, `TEC_IDX_MODE, md);
endtask
task per(input int exp);
    int k;
    k = 0;
    do begin @(posedge mclk); k++; end
    while (match_interrupt_a !== 1'b1 && k < 3000);
    if (match_interrupt_a !== 1'b1) begin err_total++; close_out; end
    k = 0;
    do begin @(posedge mclk); k++; end
    while (match_interrupt_a !== 1'b1 && k < 3000);
    if (match_interrupt_a !== 1'b1) begin err_total++; close_out; end
    chk(k, exp);
endtask
// ----------------------------------------
// sequence
// ----------------------------------------
initial begin
    srst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0000_0000;
    err_total = 0;
    n_compared = 0;
    n_match = 0;
    n_capb = 0;
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    bus(1, `TEC_IDX_CNT, 32'h0000_1234);
    for (int i = 0; i < 8; i++) rdc(3'(i), 32'h0000_0000);
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
        d = (k == 1) ? 4 : (k == 2) ? 256 : 1;
        start(3, (k == 3) ? 0 : k, (k == 3) ? 1 : 2);
        per(((k == 3) ? 2 : 3) * d);
        chk(overflow_flag, 1'b0);
    end
    $display("test interval done");
    foreach (d_es[j]) begin
        start(3, 32'h0000_0003 | (d_es[j] << 4), 32'h0000_00FF);
        repeat (2) src.pulse(0, 8, 8);
        src.pulse(0, 1, 8);
        rdc(`TEC_IDX_CNT, (j == 2) ? 4 : 2);
    end
    start(3, 32'h0000_0013, 32'h0000_0002);
    m = n_match;
    repeat (6) src.pulse(0, 8, 8);
    rdc(`TEC_IDX_CNT, 32'h0000_0000);
    chk(32'(n_match - m), 2);
    $display("test event done");
    bus(1, `TEC_IDX_CRC, 32'h0000_0000);
    start(1, 32'h0000_0010, 32'h0000_0000);
    m = n_capb;
    fork
        repeat (2) src.pulse(0, 10, 10);
        begin repeat (8) @(posedge mclk); bus(0, `TEC_IDX_CAPB, 0); end
    join
    c1 = rd;
    src.pulse(0, 1, 10);
    rdc(`TEC_IDX_CAPB, c1 + 20);
    chk(32'(n_capb - m), 2);
    start(2, 32'h0000_0010, 32'h0000_0000);
    fork
        repeat (3) src.pulse(0, 10, 10);
        begin repeat (28) @(posedge mclk); bus(0, `TEC_IDX_CAPB, 0); end
    join
    c1 = rd;
    rdc(`TEC_IDX_CAPB, c1);
    bus(1, `TEC_IDX_CRC, 32'h0000_0001);
    start(1, 32'h0000_0040, 32'h0000_0000);
    m = n_match;
    src.pulse(1, 10, 10);
    chk(32'(n_match - m), 1);
    bus(1, `TEC_IDX_CRC, 32'h0000_0003);
    start(1, 32'h0000_0010, 32'h0000_0000);
    m = n_match;
    src.pulse(0, 10, 10);
    bus(0, `TEC_IDX_CMPA, 0);
    c1 = rd;
    rdc(`TEC_IDX_CAPB, c1 - 10);
    chk(32'(n_match - m), 0);
    $display("test capture done");
    bus(1, `TEC_IDX_CRC, 32'h0000_0000);
    start(3, 32'h0000_0000, 32'h0000_8000);
    repeat (100) @(posedge mclk);
    bus(1, `TEC_IDX_CMPA, 32'h0000_0005);
    m = n_match;
    n = 0;
    while (overflow_flag !== 1'b1 && n < 70000) begin
        @(posedge mclk);
        n++;
    end
    chk(overflow_flag, 1'b1);
    chk(32'(n_match - m), 0);
    bus(1, `TEC_IDX_STAT, 32'h0000_0001);
    chk(overflow_flag, 1'b0);
    repeat (20) @(posedge mclk);
    chk(32'(n_match > m), 1);
    bus(1, `TEC_IDX_MODE, 32'h0000_0000);
    rdc(`TEC_IDX_CNT, 32'h0000_0000);
    $display("test overflow done");
    close_out;
end
endmodule

/* File: tb/tec_pulse_src.sv */
/* external pulse source on both timer input pins.
   pins idle low; changes follow rising edges of mclk. */
`timescale 1ns/1ns
module tec_pulse_src (
    input wire logic mclk,
    output logic pin_a,
    output logic pin_b
);
initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
end
// high for w cycles, then low for gap cycles
task automatic pulse(input bit on_b, input int w, input int gap);
    if (on_b)
        pin_b <= 1'b1;
    else
        pin_a <= 1'b1;
    repeat (w) @(posedge mclk);
    if (on_b)
        pin_b <= 1'b0;
    else
        pin_a <= 1'b0;
    repeat (gap) @(posedge mclk);
endtask
endmodule

/* File: tb/tec_timer_sva.sv */
/* port checker of tec_timer.
   bound at the foot of this file; sees top ports only. */
`timescale 1ns/1ns
module tec_timer_sva (
    input wire logic mclk,
    input wire logic srst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic match_interrupt_a,
    input wire logic capture_interrupt_b,
    input wire logic overflow_flag
);
default clocking cb @(posedge mclk); endclocking
default disable iff (srst);
property p_rst_quiet;
    disable iff (1'b0)
    srst |=> !match_interrupt_a && !capture_interrupt_b && !overflow_flag;
endproperty
property p_match_pulse;
    match_interrupt_a |=> !match_interrupt_a;
endproperty
property p_cap_pulse;
    capture_interrupt_b |=> !capture_interrupt_b;
endproperty
property p_ovf_sticky;
    overflow_flag && !avs_write |=> overflow_flag;
endproperty
property p_wait_first;
    $rose(avs_read) || $rose(avs_write) |-> avs_waitrequest;
endproperty
property p_wait_one;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
endproperty
property p_wait_idle;
    !avs_read && !avs_write |-> !avs_waitrequest;
endproperty
property p_rd_hold;
    !avs_read |=> $stable(avs_readdata);
endproperty
a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs not quiet after reset");
a_match_pulse: assert property (p_match_pulse)
    else $error("match pulse longer than one cycle");
a_cap_pulse: assert property (p_cap_pulse)
    else $error("capture pulse longer than one cycle");
a_ovf_sticky: assert property (p_ovf_sticky)
    else $error("overflow flag dropped by itself");
a_wait_first: assert property (p_wait_first)
    else $error("no wait on first request cycle");
a_wait_one: assert property (p_wait_one)
    else $error("wait longer than one cycle");
a_wait_idle: assert property (p_wait_idle)
    else $error("wait without request");
a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without read");
c_match: cover property (match_interrupt_a);
c_cap: cover property (capture_interrupt_b);
c_ovf: cover property ($rose(overflow_flag));
endmodule
bind tec_timer tec_timer_sva u_sva (.mclk(mclk), .srst(srst),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .match_interrupt_a(match_interrupt_a),
    .capture_interrupt_b(capture_interrupt_b),
    .overflow_flag(overflow_flag));

/* File: verilog/tec_edge_filt.sv */
/*
 * noise filter for one timer input: a level is accepted only
 * after two equal samples, then a rise or fall pulse is given.
 * assumes smp_en is a one-cycle enable on mclk.
 */
`timescale 1ns/1ns
module tec_edge_filt
    import tec_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    tec_edge_if.filt eif
);
    logic smp_r, smp_nxt;
    logic lvl_r, lvl_nxt;
    logic rise_r, rise_nxt;
    logic fall_r, fall_nxt;

    // ------------------------------------------------------------
    // two-sample level check
    // ------------------------------------------------------------
    always_comb begin
        smp_nxt = smp_r;
        lvl_nxt = lvl_r;
        rise_nxt = 1'b0;
        fall_nxt = 1'b0;
        if (eif.smp_en) begin
            smp_nxt = eif.pin_s;
            if (eif.pin_s == smp_r && eif.pin_s != lvl_r) begin
                lvl_nxt = eif.pin_s;
                rise_nxt = eif.pin_s;
                fall_nxt = ~eif.pin_s;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            smp_r <= 1'b0;
            lvl_r <= 1'b0;
            rise_r <= 1'b0;
            fall_r <= 1'b0;
        end else begin
            smp_r <= smp_nxt;
            lvl_r <= lvl_nxt;
            rise_r <= rise_nxt;
            fall_r <= fall_nxt;
        end
    end

    assign eif.rise = rise_r;
    assign eif.fall = fall_r;
endmodule

/* File: verilog/tec_edge_if.sv */
/*
 * carrier between the counter core and an input edge filter.
 * assumes pin_s is already synchronised to mclk.
 */
`timescale 1ns/1ns
interface tec_edge_if;
    logic smp_en;
    logic pin_s;
    logic rise;
    logic fall;
    modport filt (input smp_en, input pin_s, output rise, output fall);
    modport core (output smp_en, output pin_s, input rise, input fall);
endinterface

/* File: verilog/tec_pkg.sv */
/*
 * types of the timer/event counter.
 * assumes tec_regs.svh supplies the numeric constants.
 */
package tec_pkg;

    // operating mode, gray coded along stop/free/match/edge
    typedef enum logic [1:0] {
        TEC_STOP = 2'h0,
        TEC_FREE = 2'h1,
        TEC_CLR_MATCH = 2'h3,
        TEC_CLR_EDGE = 2'h2
    } tec_mode_t;

    // count clock source
    typedef enum logic [1:0] {
        TEC_CK_DIV1 = 2'h0,
        TEC_CK_DIV4 = 2'h1,
        TEC_CK_DIV256 = 2'h2,
        TEC_CK_EDGE = 2'h3
    } tec_clk_t;

    // valid edge selection
    typedef enum logic [1:0] {
        TEC_ES_FALL = 2'h0,
        TEC_ES_RISE = 2'h1,
        TEC_ES_BAD = 2'h2,
        TEC_ES_BOTH = 2'h3
    } tec_es_t;

endpackage

/* File: verilog/tec_regs.svh */
/*
 * register offsets, field positions, reset values and divider
 * counts of the timer/event counter.
 * assumes avalon byte addresses, one 32-bit word per register.
 */
`ifndef TEC_REGS_SVH
`define TEC_REGS_SVH

// ------------------------------------------------------------
// register word indices (byte address = index * 4)
// ------------------------------------------------------------
`define TEC_IDX_MODE 3'h0
`define TEC_IDX_CRC 3'h1
`define TEC_IDX_PRM 3'h2
`define TEC_IDX_CMPA 3'h3
`define TEC_IDX_CAPB 3'h4
`define TEC_IDX_CNT 3'h5
`define TEC_IDX_STAT 3'h6

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define TEC_PRM_CLK_LO 0
`define TEC_PRM_CLK_HI 1
`define TEC_PRM_ESA_LO 4
`define TEC_PRM_ESA_HI 5
`define TEC_PRM_ESB_LO 6
`define TEC_PRM_ESB_HI 7
`define TEC_CRC_A_CAP 0
`define TEC_CRC_A_REV 1
`define TEC_STAT_OVF 0

// ------------------------------------------------------------
// reset values and constants
// ------------------------------------------------------------
`define TEC_RST_PRM 8'h00
`define TEC_RST_CRC 2'h0
`define TEC_RST_CMPA 16'h0000
`define TEC_CNT_ZERO 16'h0000
`define TEC_CNT_TOP 16'hFFFF
`define TEC_CNT_ONE 16'h0001
`define TEC_DIV4_LAST 8'h03
`define TEC_DIV256_LAST 8'hFF
`define TEC_DIV_ONE 8'h01
`define TEC_DIV_ZERO 8'h00
`define TEC_DIV256_MASK 8'hFF
`define TEC_DIV4_MASK 8'h03

`endif

/* File: verilog/tec_timer.sv */
/*
 * 16-bit timer/event counter with interval, event count and
 * pulse width capture, reached over avalon-mm with waitrequest.
 * assumes edge_input_a/b are asynchronous pins; one clock mclk.
 */
// Functional notes
// - interval mode: clear on match, pulse match irq
// - period is compare value plus one
// - prescaler bits 1:0 choose count clock
// - overflow whenever the count wraps from FFFFH
// - lowered compare: run to overflow, wrap
// - event mode counts each valid input edge
// - event mode: clear on match, match irq
// - prescaler bits 5:4 pick event edge
// - event edge filtered by two fxp samples
// - event count starts after filtered edge
// - capture free-running or restart on edge
// - capture input sampled twice at count clock
// - capture latches counter, pulses capture irq
// - edge codes: 00 fall, 01 rise, 11 both
// - clock: fxp, fxp/4, fxp/256, input edge
`timescale 1ns/1ns
`include "tec_regs.svh"
module tec_timer
    import tec_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic edge_input_a,
    input wire logic edge_input_b,
    output logic match_interrupt_a,
    output logic capture_interrupt_b,
    output logic overflow_flag
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic edge_hit(input logic [1:0] sel,
                                      input logic rise,
                                      input logic fall);
        case (tec_es_t'(sel))
            TEC_ES_FALL: edge_hit = fall;
            TEC_ES_RISE: edge_hit = rise;
            TEC_ES_BOTH: edge_hit = rise | fall;
            TEC_ES_BAD: edge_hit = 1'b0; // prohibited code never hits
            default: edge_hit = 1'b0;
        endcase
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
        merge16 = {be[1] ? wd[15:8] : old[15:8],
                   be[0] ? wd[7:0] : old[7:0]};
    endfunction

    function automatic logic div_hit(input logic [7:0] cnt,
                                     input logic [7:0] mask,
                                     input logic [7:0] last);
        div_hit = ((cnt & mask) == last);
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers and filters
    // ------------------------------------------------------------
    logic a_m_r, a_s_r, b_m_r, b_s_r;
    logic a_m_nxt, a_s_nxt, b_m_nxt, b_s_nxt;

    // two flops before the filters read either pin
    always_comb begin
        a_m_nxt = edge_input_a;
        a_s_nxt = a_m_r;
        b_m_nxt = edge_input_b;
        b_s_nxt = b_m_r;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            a_m_r <= 1'b0;
            a_s_r <= 1'b0;
            b_m_r <= 1'b0;
            b_s_r <= 1'b0;
        end else begin
            a_m_r <= a_m_nxt;
            a_s_r <= a_s_nxt;
            b_m_r <= b_m_nxt;
            b_s_r <= b_s_nxt;
        end
    end

    tec_edge_if eif_a ();
    tec_edge_if eif_b ();

    tec_edge_filt u_filt_a (
        .mclk(mclk),
        .srst(srst),
        .eif(eif_a.filt)
    );

    tec_edge_filt u_filt_b (
        .mclk(mclk),
        .srst(srst),
        .eif(eif_b.filt)
    );

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    tec_mode_t mode_r, mode_nxt;
    logic [1:0] crc_r, crc_nxt;
    logic [7:0] prm_r, prm_nxt;
    logic [15:0] cmpa_r, cmpa_nxt;
    logic [15:0] capb_r, capb_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic [7:0] div_r, div_nxt;
    logic ovf_r, ovf_nxt;
    logic mirq_r, mirq_nxt;
    logic cirq_r, cirq_nxt;
    logic ack_r, ack_nxt;
    logic [31:0] rd_r, rd_nxt;

    logic run, tick, es_a, es_b, rev_a, wr_en;
    logic [2:0] idx;
    tec_clk_t ck_sel;

    assign idx = avs_address[4:2];
    // a write lands at the edge that sees waitrequest low
    assign wr_en = avs_write & ack_r;
    assign run = (mode_r != TEC_STOP);
    assign ck_sel = tec_clk_t'(prm_r[`TEC_PRM_CLK_HI:`TEC_PRM_CLK_LO]);

    // edge input sampled at fxp for counting, else at count clock
    assign eif_a.pin_s = a_s_r;
    assign eif_b.pin_s = b_s_r;
    assign eif_a.smp_en = (ck_sel == TEC_CK_EDGE) ? 1'b1 : tick;
    assign eif_b.smp_en = (ck_sel == TEC_CK_EDGE) ? 1'b1 : tick;

    assign es_a = run & edge_hit(prm_r[`TEC_PRM_ESA_HI:`TEC_PRM_ESA_LO],
                                 eif_a.rise, eif_a.fall);
    assign es_b = run & edge_hit(prm_r[`TEC_PRM_ESB_HI:`TEC_PRM_ESB_LO],
                                 eif_b.rise, eif_b.fall);
    // opposite edge of input a, for the two-register capture
    assign rev_a = run & (edge_hit(prm_r[`TEC_PRM_ESA_HI:`TEC_PRM_ESA_LO],
                                   eif_a.fall, eif_a.rise));

    // ------------------------------------------------------------
    // count clock selection
    // ------------------------------------------------------------
    always_comb begin
        case (ck_sel)
            TEC_CK_DIV1: tick = run;
            TEC_CK_DIV4: tick = run &
                div_hit(div_r, `TEC_DIV4_MASK, `TEC_DIV4_LAST);
            TEC_CK_DIV256: tick = run &
                div_hit(div_r, `TEC_DIV256_MASK, `TEC_DIV256_LAST);
            TEC_CK_EDGE: tick = es_a;
            default: tick = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // counter, captures and flags
    // ------------------------------------------------------------
    always_comb begin
        mode_nxt = mode_r;
        crc_nxt = crc_r;
        prm_nxt = prm_r;
        cmpa_nxt = cmpa_r;
        capb_nxt = capb_r;
        cnt_nxt = cnt_r;
        // divider restarts whenever the timer stops
        div_nxt = run ? div_r + `TEC_DIV_ONE : `TEC_DIV_ZERO;
        ovf_nxt = ovf_r;
        mirq_nxt = 1'b0;
        cirq_nxt = 1'b0;

        if (!run) begin
            cnt_nxt = `TEC_CNT_ZERO;
        end else if (tick) begin
            if (cnt_r == `TEC_CNT_TOP) begin
                cnt_nxt = `TEC_CNT_ZERO;
            end else begin
                cnt_nxt = cnt_r + `TEC_CNT_ONE;
            end
            if (!crc_r[`TEC_CRC_A_CAP] && cnt_r == cmpa_r) begin
                mirq_nxt = 1'b1;
                if (mode_r == TEC_CLR_MATCH) begin
                    cnt_nxt = `TEC_CNT_ZERO;
                end
            end
        end

        // restart on edge of input a, after capturing into b
        if (mode_r == TEC_CLR_EDGE && es_a) begin
            cnt_nxt = `TEC_CNT_ZERO;
        end
        if ((mode_r == TEC_FREE || mode_r == TEC_CLR_EDGE) && es_a) begin
            capb_nxt = cnt_r;
            cirq_nxt = 1'b1;
        end
        if (crc_r[`TEC_CRC_A_CAP]) begin
            if (crc_r[`TEC_CRC_A_REV] ? rev_a : es_b) begin
                cmpa_nxt = cnt_r;
                mirq_nxt = ~crc_r[`TEC_CRC_A_REV];
            end
        end

        // software writes; status is write-one-to-clear
        if (wr_en) begin
            case (idx)
                `TEC_IDX_MODE: if (avs_byteenable[0])
                    mode_nxt = tec_mode_t'(avs_writedata[1:0]);
                `TEC_IDX_CRC: if (avs_byteenable[0])
                    crc_nxt = avs_writedata[1:0];
                `TEC_IDX_PRM: if (avs_byteenable[0])
                    prm_nxt = avs_writedata[7:0];
                `TEC_IDX_CMPA:
                    cmpa_nxt = merge16(cmpa_r, avs_writedata, avs_byteenable);
                `TEC_IDX_STAT:
                    if (avs_byteenable[0] && avs_writedata[`TEC_STAT_OVF])
                        ovf_nxt = 1'b0;
                `TEC_IDX_CAPB, `TEC_IDX_CNT: ; // read only
                default: ;
            endcase
        end
        // set wins over a simultaneous clear
        if (tick && cnt_r == `TEC_CNT_TOP) begin
            ovf_nxt = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // avalon slave: one wait cycle, read data from flops
    // ------------------------------------------------------------
    always_comb begin
        ack_nxt = (avs_read | avs_write) & ~ack_r;
        rd_nxt = rd_r;
        if (avs_read && !ack_r) begin
            case (idx)
                `TEC_IDX_MODE: rd_nxt = {30'h0000_0000, mode_r};
                `TEC_IDX_CRC: rd_nxt = {30'h0000_0000, crc_r};
                `TEC_IDX_PRM: rd_nxt = {24'h00_0000, prm_r};
                `TEC_IDX_CMPA: rd_nxt = {16'h0000, cmpa_r};
                `TEC_IDX_CAPB: rd_nxt = {16'h0000, capb_r};
                `TEC_IDX_CNT: rd_nxt = {16'h0000, cnt_r};
                `TEC_IDX_STAT: rd_nxt = {31'h0000_0000, ovf_r};
                default: rd_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            ack_r <= 1'b0;
            rd_r <= 32'h0000_0000;
        end else begin
            ack_r <= ack_nxt;
            rd_r <= rd_nxt;
        end
    end

    // ------------------------------------------------------------
    // counter and register state
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            mode_r <= TEC_STOP;
            crc_r <= `TEC_RST_CRC;
            prm_r <= `TEC_RST_PRM;
            cmpa_r <= `TEC_RST_CMPA;
            capb_r <= `TEC_CNT_ZERO;
            cnt_r <= `TEC_CNT_ZERO;
            div_r <= `TEC_DIV_ZERO;
            ovf_r <= 1'b0;
            mirq_r <= 1'b0;
            cirq_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            crc_r <= crc_nxt;
            prm_r <= prm_nxt;
            cmpa_r <= cmpa_nxt;
            capb_r <= capb_nxt;
            cnt_r <= cnt_nxt;
            div_r <= div_nxt;
            ovf_r <= ovf_nxt;
            mirq_r <= mirq_nxt;
            cirq_r <= cirq_nxt;
        end
    end

    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
    assign avs_readdata = rd_r;
    assign match_interrupt_a = mirq_r;
    assign capture_interrupt_b = cirq_r;
    assign overflow_flag = ovf_r;
endmodule
